// ===== common/gts_pkg.sv
// Constants and types shared by the general timer set.
// Assumes a single system clock and a plain strobe register port.
package gts_pkg;

  localparam int N_TMR = 5;
  localparam int AW    = 5;
  localparam int DW    = 16;

  // Timer i owns three words starting at REGS_PER_TMR * i.
  localparam logic [AW-1:0] REGS_PER_TMR = 5'h03;
  localparam logic [AW-1:0] OFS_CTL      = 5'h00;
  localparam logic [AW-1:0] OFS_CNT      = 5'h01;
  localparam logic [AW-1:0] OFS_PER      = 5'h02;
  localparam logic [AW-1:0] ADDR_STAT    = 5'h0f;
  localparam logic [AW-1:0] ADDR_MASK    = 5'h10;

  // Writable bits of the three control register kinds.
  localparam logic [DW-1:0] MASK_SA = 16'ha076;
  localparam logic [DW-1:0] MASK_LO = 16'ha07a;
  localparam logic [DW-1:0] MASK_HI = 16'ha072;

  localparam logic [DW-1:0] CTL_RST = 16'h0000;
  localparam logic [DW-1:0] CNT_RST = 16'h0000;
  localparam logic [DW-1:0] PER_RST = 16'hffff;

  // Last prescaler state for each ratio.
  localparam logic [7:0] PSC_LAST_1   = 8'h00;
  localparam logic [7:0] PSC_LAST_8   = 8'h07;
  localparam logic [7:0] PSC_LAST_64  = 8'h3f;
  localparam logic [7:0] PSC_LAST_256 = 8'hff;

  typedef struct packed {
    logic       run;
    logic       rsv14;
    logic       idle_stop;
    logic [5:0] rsv12_7;
    logic       gate;
    logic [1:0] presc;
    logic       wide;
    logic       sync;
    logic       csrc;
    logic       rsv0;
  } gts_ctl_t;

endpackage : gts_pkg

// ===== src/gts_timer_set.sv
// General timer set: one standalone 16-bit timer and two pairs that
// may join into 32-bit timers. Assumes a single clock, count pins from
// outside that domain, and a register master that never waits.
`timescale 1ns/10ps
module gts_timer_set (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [gts_pkg::AW-1:0]  addr,
  input  wire logic [gts_pkg::DW-1:0]  wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output      logic [gts_pkg::DW-1:0]  rd_data,
  input  wire logic [4:0]              external_count_pin,
  input  wire logic                    idle_mode,
  output      logic                    irq,
  output      logic                    adc_trigger
);

  localparam int NT = gts_pkg::N_TMR;

  function automatic logic [gts_pkg::AW-1:0] reg_addr(input int i,
                                                      input logic [4:0] ofs);
    reg_addr = 5'(i * gts_pkg::REGS_PER_TMR) + ofs;
  endfunction : reg_addr

  function automatic logic [15:0] ctl_mask(input int i);
    if (i == 0) ctl_mask = gts_pkg::MASK_SA;
    else if (i % 2 == 1) ctl_mask = gts_pkg::MASK_LO;
    else ctl_mask = gts_pkg::MASK_HI;
  endfunction : ctl_mask

  function automatic logic [7:0] psc_last(input logic [1:0] sel);
    unique case (sel)
      2'h3: psc_last = gts_pkg::PSC_LAST_256;
      2'h2: psc_last = gts_pkg::PSC_LAST_64;
      2'h1: psc_last = gts_pkg::PSC_LAST_8;
      2'h0: psc_last = gts_pkg::PSC_LAST_1;
    endcase
  endfunction : psc_last

  logic [15:0]  ctl_r [NT];
  logic [15:0]  cnt_r [NT];
  logic [15:0]  cnt_nxt [NT];
  logic [15:0]  per_r [NT];
  logic [4:0]   stat_r;
  logic [4:0]   mask_r;
  logic [4:0]   evt;
  logic [4:0]   tick;
  logic [4:0]   gfall;
  logic [4:0]   ext_s1_r;
  logic [4:0]   ext_s2_r;
  logic [4:0]   ext_s3_r;
  logic         phase_r;
  logic [15:0]  rd_data_r;
  logic         irq_r;
  logic         adc_r;

  assign rd_data     = rd_data_r;
  assign irq         = irq_r;
  assign adc_trigger = adc_r;

  // Pins cross into the clock domain through two flops; s3 keeps the
  // previous settled level for edge detection.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 5'h00;
      ext_s2_r <= 5'h00;
      ext_s3_r <= 5'h00;
    end else begin
      ext_s1_r <= external_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) phase_r <= 1'b0;
    else phase_r <= ~phase_r;
  end

  genvar gi;
  for (gi = 0; gi < NT; gi++) begin : g_tmr
    gts_pkg::gts_ctl_t c;
    logic              hold;
    logic              run;
    logic              edge_in;
    logic              fall_in;
    logic              raw;
    logic              pend_r;
    logic [7:0]        pre_r;

    assign c       = gts_pkg::gts_ctl_t'(ctl_r[gi]);
    assign edge_in = ext_s2_r[gi] & ~ext_s3_r[gi];
    assign fall_in = ext_s3_r[gi] & ~ext_s2_r[gi];

    if (gi == 2 || gi == 4) begin : g_up
      assign hold = ctl_r[gi-1][3];
    end else begin : g_nup
      assign hold = 1'b0;
    end

    assign run = c.run & ~(c.idle_stop & idle_mode) & ~hold;

    always_comb begin
      if (c.csrc) begin
        if (gi == 0 && !c.sync) raw = edge_in;
        else raw = phase_r & (pend_r | edge_in);
      end else begin
        raw = phase_r & (~c.gate | ext_s2_r[gi]);
      end
    end

    // Edges seen in the off phase wait for the next instruction tick.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pend_r <= 1'b0;
      else pend_r <= c.csrc & ~phase_r & (pend_r | edge_in);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pre_r <= 8'h00;
      else if (!run) pre_r <= 8'h00;
      else if (raw) pre_r <= (pre_r == psc_last(c.presc)) ? 8'h00 : pre_r + 8'h01;
    end

    assign tick[gi]  = run & raw & (pre_r == psc_last(c.presc));
    assign gfall[gi] = run & ~c.csrc & c.gate & fall_in;
  end

  // Next counts and flag events; software writes override counting.
  always_comb begin
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    evt = gfall;
    for (int i = 0; i < NT; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (tick[i]) begin
        if (cnt_r[i] == per_r[i]) begin
          cnt_nxt[i] = 16'h0000;
          evt[i] = 1'b1;
        end else begin
          cnt_nxt[i] = cnt_r[i] + 16'h0001;
        end
      end
    end
    for (int p = 0; p < 2; p++) begin
      lo = 1 + 2 * p;
      hi = lo + 1;
      if (ctl_r[lo][3]) begin
        evt[lo] = 1'b0;
        evt[hi] = gfall[lo];
        cnt_nxt[lo] = cnt_r[lo];
        if (tick[lo]) begin
          if ({cnt_r[hi], cnt_r[lo]} == {per_r[hi], per_r[lo]}) begin
            cnt_nxt[lo] = 16'h0000;
            cnt_nxt[hi] = 16'h0000;
            evt[hi] = 1'b1;
          end else begin
            cnt_nxt[lo] = cnt_r[lo] + 16'h0001;
            if (cnt_r[lo] == 16'hffff) cnt_nxt[hi] = cnt_r[hi] + 16'h0001;
          end
        end
      end
    end
    for (int i = 0; i < NT; i++) begin
      if (wr_en && addr == reg_addr(i, gts_pkg::OFS_CNT)) cnt_nxt[i] = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NT; i++) cnt_r[i] <= gts_pkg::CNT_RST;
    end else begin
      for (int i = 0; i < NT; i++) cnt_r[i] <= cnt_nxt[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NT; i++) ctl_r[i] <= gts_pkg::CTL_RST;
    end else if (wr_en) begin
      for (int i = 0; i < NT; i++) begin
        if (addr == reg_addr(i, gts_pkg::OFS_CTL)) ctl_r[i] <= wr_data & ctl_mask(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NT; i++) per_r[i] <= gts_pkg::PER_RST;
    end else if (wr_en) begin
      for (int i = 0; i < NT; i++) begin
        if (addr == reg_addr(i, gts_pkg::OFS_PER)) per_r[i] <= wr_data;
      end
    end
  end

  // Status bits are write-one-to-clear; a new event wins over a clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) stat_r <= 5'h00;
    else if (wr_en && addr == gts_pkg::ADDR_STAT) stat_r <= (stat_r & ~wr_data[4:0]) | evt;
    else stat_r <= stat_r | evt;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) mask_r <= 5'h00;
    else if (wr_en && addr == gts_pkg::ADDR_MASK) mask_r <= wr_data[4:0];
  end

  // The interrupt level lags the status bits by one cycle so that it
  // leaves a flop.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) irq_r <= 1'b0;
    else irq_r <= |(stat_r & mask_r);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) adc_r <= 1'b0;
    else adc_r <= evt[4];
  end

  // Unmapped addresses read as zero; data stand for one cycle only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= 16'h0000;
      if (rd_en) begin
        for (int i = 0; i < NT; i++) begin
          if (addr == reg_addr(i, gts_pkg::OFS_CTL)) rd_data_r <= ctl_r[i];
          if (addr == reg_addr(i, gts_pkg::OFS_CNT)) rd_data_r <= cnt_r[i];
          if (addr == reg_addr(i, gts_pkg::OFS_PER)) rd_data_r <= per_r[i];
        end
        if (addr == gts_pkg::ADDR_STAT) rd_data_r <= {11'h000, stat_r};
        if (addr == gts_pkg::ADDR_MASK) rd_data_r <= {11'h000, mask_r};
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic wr_cnt0;
  assign wr_cnt0 = wr_en && addr == reg_addr(0, gts_pkg::OFS_CNT);

  property p_stop_holds;
    !ctl_r[0][15] && !wr_cnt0 |=> cnt_r[0] == $past(cnt_r[0]);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stopped timer changed count");

  property p_idle_halt;
    ctl_r[0][13] && idle_mode |-> !tick[0];
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("timer ticked in idle with idle stop set");

  property p_gate_low;
    !ctl_r[0][1] && ctl_r[0][6] && !ext_s2_r[0] |-> !g_tmr[0].raw;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("gated count while gate low");

  property p_presc;
    tick[0] |-> g_tmr[0].pre_r == psc_last(ctl_r[0][5:4]);
  endproperty
  a_presc: assert property (p_presc)
    else $error("tick off prescale boundary");

  property p_sync_phase;
    ctl_r[1][1] && g_tmr[1].raw |-> phase_r;
  endproperty
  a_sync_phase: assert property (p_sync_phase)
    else $error("paired counter not synchronous");

  property p_wrap;
    tick[0] && cnt_r[0] == per_r[0] && !wr_cnt0
      |=> cnt_r[0] == 16'h0000 && stat_r[0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap and flag at period");

  property p_wide_flag;
    ctl_r[3][3] && tick[3] && {cnt_r[4], cnt_r[3]} == {per_r[4], per_r[3]}
      && !gfall[3] |=> stat_r[4] && !$rose(stat_r[3]);
  endproperty
  a_wide_flag: assert property (p_wide_flag)
    else $error("joined match flagged wrong timer");

  property p_upper_ignored;
    ctl_r[3][3] |-> !tick[4];
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("joined upper counted on its own");

  property p_adc;
    adc_trigger |-> $past(evt[4]);
  endproperty
  a_adc: assert property (p_adc)
    else $error("trigger without second pair event");

  property p_unused_zero;
    (ctl_r[0] & ~gts_pkg::MASK_SA) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unimplemented control bit set");

  c_wide_match: cover property (ctl_r[3][3] && evt[4]);
  c_gate_fall:  cover property (gfall[0]);
  c_adc:        cover property (adc_trigger);

endmodule : gts_timer_set

// ===== tb/gts_pin_drv.sv
// Far-side model of the five count and gate pins.
// Assumes the bench calls one task at a time.
`timescale 1ns/10ps
module gts_pin_drv (
  input  wire logic       ref_clk,
  output      logic [4:0] pins
);
  initial pins = 5'h00;

  task automatic edges(input int idx, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      pins[idx] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins[idx] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : edges

  task automatic level(input int idx, input logic v);
    @(posedge ref_clk);
    pins[idx] <= v;
  endtask : level
endmodule : gts_pin_drv

// ===== tb/tb_top.sv
// Self-checking bench for the timer set.
// Assumes the register map and masks of the shared package.
`timescale 1ns/10ps
module tb_top;
  logic                   ref_clk, rst_n, wr_en, rd_en, idle_mode, irq, adc_trigger, rd_v;
  logic [gts_pkg::AW-1:0] addr;
  logic [gts_pkg::DW-1:0] wr_data, rd_data, m;
  logic [4:0]             pins;
  logic [31:0]            seed;
  logic [15:0]            exp_q[$];
  int                     err_count, num_checks, i;
  int                     ne[4] = '{3, 16, 128, 256};
  logic [15:0]            ce[4] = '{16'h0003, 16'h0002, 16'h0002, 16'h0001};

  gts_timer_set i_gts_timer_set (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .external_count_pin(pins), .idle_mode(idle_mode), .irq(irq),
    .adc_trigger(adc_trigger));
  gts_pin_drv i_gts_pin_drv (.ref_clk(ref_clk), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic ok, input string s);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t %s", $time, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [4:0] ad(input int t, input logic [4:0] o);
    return gts_pkg::REGS_PER_TMR * 5'(t) + o;
  endfunction : ad

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // The expected word is noted before the strobe; the watcher compares it.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask : rd

  // Pulses are looked at mid-cycle so the launching edge has settled.
  task automatic wait_sig(input bit adc);
    int n;
    n = 0;
    while (((adc ? adc_trigger : irq) !== 1'b1) && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      chk(1'b0, "timeout");
      stop_test();
    end
  endtask : wait_sig

  always @(posedge ref_clk) rd_v <= rd_en;
  always @(negedge ref_clk) begin
    if (rd_v) begin
      if (exp_q.size() == 0)
        chk(1'b0, "read without note");
      else
        chk(rd_data === exp_q.pop_front(), "read data");
    end
  end

  initial begin
    {rst_n, wr_en, rd_en, idle_mode} = 4'h0;
    addr = 5'h00;
    wr_data = 16'h0000;
    seed = 32'd91;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(ad(i, gts_pkg::OFS_CTL), gts_pkg::CTL_RST);
      rd(ad(i, gts_pkg::OFS_PER), gts_pkg::PER_RST);
      seed = xs(seed);
      wr(ad(i, gts_pkg::OFS_PER), seed[15:0]);
      rd(ad(i, gts_pkg::OFS_PER), seed[15:0]);
    end
    rd(gts_pkg::ADDR_STAT, 16'h0000);
    rd(5'h11, 16'h0000);
    for (i = 0; i < 3; i++) begin
      m = (i == 0) ? gts_pkg::MASK_SA : (i == 1) ? gts_pkg::MASK_LO : gts_pkg::MASK_HI;
      wr(ad(i, gts_pkg::OFS_CTL), 16'h7fff);
      rd(ad(i, gts_pkg::OFS_CTL), m & 16'h7fff);
      wr(ad(i, gts_pkg::OFS_CTL), 16'h0000);
    end
    $display("test registers done");
    wr(ad(0, gts_pkg::OFS_PER), 16'h0002);
    wr(ad(0, gts_pkg::OFS_CNT), 16'h0000);
    wr(gts_pkg::ADDR_MASK, 16'h0001);
    @(posedge ref_clk);
    idle_mode <= 1'b1;
    wr(ad(0, gts_pkg::OFS_CTL), 16'ha000);
    repeat (20) @(posedge ref_clk);
    rd(ad(0, gts_pkg::OFS_CNT), 16'h0000);
    rd(gts_pkg::ADDR_STAT, 16'h0000);
    idle_mode <= 1'b0;
    wait_sig(0);
    wr(ad(0, gts_pkg::OFS_CTL), 16'h0000);
    rd(gts_pkg::ADDR_STAT, 16'h0001);
    wr(gts_pkg::ADDR_STAT, 16'h0001);
    repeat (3) @(negedge ref_clk);
    chk(irq === 1'b0, "irq after clear");
    $display("test period done");
    wr(ad(1, gts_pkg::OFS_PER), 16'hffff);
    for (i = 0; i < 4; i++) begin
      wr(ad(1, gts_pkg::OFS_CTL), 16'h0000);
      wr(ad(1, gts_pkg::OFS_CNT), 16'h0000);
      wr(ad(1, gts_pkg::OFS_CTL), 16'h8002 | (16'(i) << 4));
      i_gts_pin_drv.edges(1, ne[i]);
      repeat (8) @(posedge ref_clk);
      rd(ad(1, gts_pkg::OFS_CNT), ce[i]);
    end
    wr(ad(1, gts_pkg::OFS_CTL), 16'h0000);
    $display("test prescale done");
    wr(ad(0, gts_pkg::OFS_PER), 16'hffff);
    wr(ad(0, gts_pkg::OFS_CTL), 16'h8040);
    i_gts_pin_drv.level(0, 1'b1);
    repeat (20) @(posedge ref_clk);
    i_gts_pin_drv.level(0, 1'b0);
    repeat (8) @(posedge ref_clk);
    rd(gts_pkg::ADDR_STAT, 16'h0001);
    wr(ad(0, gts_pkg::OFS_CTL), 16'h0000);
    wr(gts_pkg::ADDR_STAT, 16'h0001);
    $display("test gate done");
    // Standalone external count, unsynchronised and then synchronised.
    for (i = 0; i < 2; i++) begin
      wr(ad(0, gts_pkg::OFS_CTL), 16'h0000);
      wr(ad(0, gts_pkg::OFS_CNT), 16'h0000);
      wr(ad(0, gts_pkg::OFS_CTL), 16'h8002 | (16'(i) << 2));
      i_gts_pin_drv.edges(0, 3);
      repeat (8) @(posedge ref_clk);
      rd(ad(0, gts_pkg::OFS_CNT), 16'h0003);
    end
    wr(ad(0, gts_pkg::OFS_CTL), 16'h0000);
    $display("test modes done");
    wr(ad(3, gts_pkg::OFS_PER), 16'h0001);
    wr(ad(4, gts_pkg::OFS_PER), 16'h0000);
    // The upper timer is told to run; joined, it must stay still.
    wr(ad(4, gts_pkg::OFS_CTL), 16'h8030);
    wr(ad(3, gts_pkg::OFS_CTL), 16'h8008);
    wait_sig(1);
    wr(ad(3, gts_pkg::OFS_CTL), 16'h0000);
    rd(gts_pkg::ADDR_STAT, 16'h0010);
    wr(ad(4, gts_pkg::OFS_CTL), 16'h0000);
    repeat (3) @(posedge ref_clk);
    $display("test pair done");
    stop_test();
  end
endmodule : tb_top
